// File: hw/mfi_pkg.sv
// constants, field layout and carrier types for the multi-function
// interrupt flag and enable registers.
// assumes one 50 MHz clock and an active-low asynchronous reset.
//
// Functional notes
// RULE1: group 0 std timer0 cmp-A: flag 7, enable 3
// RULE2: group 0 std timer0 cmp-P: flag 6, enable 2
// RULE3: group 0 per timer0 cmp-A: flag 5, enable 1
// RULE4: group 0 per timer0 cmp-P: flag 4, enable 0
// RULE5: group 1 std timer1 cmp-A: flag 7, enable 3
// RULE6: group 1 std timer1 cmp-P: flag 6, enable 2
// RULE7: group 1 per timer1 cmp-A: flag 5, enable 1
// RULE8: group 1 per timer1 cmp-P: flag 4, enable 0
// RULE9: group 2 per timer2 cmp-A: flag 5, enable 1
// RULE10: group 2 per timer2 cmp-P: flag 4, enable 0
// RULE11: group 2 bits 7,6,3,2 read zero
// RULE12: group 3 serial module: flag 7, enable 3
// RULE13: group 3 spi unit: flag 6, enable 2
// RULE14: group 3 eeprom event: flag 5, enable 1
// RULE15: group 3 low voltage: flag 4, enable 0
// RULE16: flags read pending state, software reads/writes
// RULE17: enables gate requests, software reads/writes
// RULE18: request only when flag and enable high
// RULE19: global enable gates all, cleared on service
// RULE20: any flag rising wakes from sleep/idle
// RULE21: reset to zero; enabled flags form group request
////////////////////////////////////////////////////////////////////////

package mfi_pkg;

    localparam int          ADDR_W    = 3;
    localparam int          NGRP      = 4;

    localparam logic [2:0]  OFF_GRP0  = 3'h0;
    localparam logic [2:0]  OFF_GRP1  = 3'h1;
    localparam logic [2:0]  OFF_GRP2  = 3'h2;
    localparam logic [2:0]  OFF_GRP3  = 3'h3;
    localparam logic [2:0]  OFF_CTRL  = 3'h4;

    // flag of source s sits at FLAG_LSB + s, its enable at s
    localparam int          FLAG_LSB  = 4;
    localparam int          GIE_BIT   = 0;

    localparam int          SRC_A_STD = 3;
    localparam int          SRC_P_STD = 2;
    localparam int          SRC_A_PER = 1;
    localparam int          SRC_P_PER = 0;
    localparam int          SRC_SER   = 3;
    localparam int          SRC_SPI   = 2;
    localparam int          SRC_EEP   = 1;
    localparam int          SRC_LVOLT = 0;

    // implemented sources per group, group 3 first
    localparam logic [3:0][3:0] IMPL_MASK = {4'hf, 4'h3, 4'hf, 4'hf};

    localparam logic [3:0]  RST_NIB   = 4'h0;
    localparam logic        RST_GIE   = 1'b0;
    localparam logic [7:0]  RD_ZERO   = 8'h00;

    typedef logic [3:0] mfi_nib_t;

    // one-cycle hardware event pulses, bit order as the flag nibble
    typedef struct packed {
        mfi_nib_t grp3;
        mfi_nib_t grp2;
        mfi_nib_t grp1;
        mfi_nib_t grp0;
    } mfi_evt_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } mfi_bus_s;

endpackage

// File: hw/mfi_irq_flags.sv
// request flags, enables and global enable for the four
// multi-function interrupt groups, with a one-cycle register port.
// assumes event inputs are single-cycle pulses synchronous to clk.
////////////////////////////////////////////////////////////////////////
//
// The plain strobed port and the placing of the registers were decided locally.

`timescale 1ns/1ps

module mfi_irq_flags
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire mfi_pkg::mfi_bus_s bus,
    input  wire mfi_pkg::mfi_evt_s evt,
    input  wire logic              svc_ack,
    input  wire logic              sleep_or_idle,
    output logic [7:0]             rd_data,
    output logic [3:0]             mf_req,
    output logic                   irq_req,
    output logic                   global_irq_enable,
    output logic                   wake
);
    import mfi_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state

    logic [3:0][3:0] flag;
    logic [3:0][3:0] ena;
    logic [3:0][3:0] next_flag;
    logic [3:0][3:0] next_ena;
    logic [3:0][3:0] evt_v;
    logic            next_gie;
    logic [7:0]      next_rd_data;
    logic [3:0]      next_mf_req;
    logic            next_wake;

    assign evt_v = {evt.grp3, evt.grp2, evt.grp1, evt.grp0};

    ////////////////////////////////////////////////////////////////////
    // flag, enable and global enable update

    always_comb
    begin
        next_flag = flag;
        next_ena  = ena;
        next_gie  = global_irq_enable;
        for (int g = 0; g < NGRP; g++)
        begin
            if (bus.wr && bus.addr == ADDR_W'(g))
            begin
                // unimplemented bits never store
                next_flag[g] = bus.wdata[7:FLAG_LSB] & IMPL_MASK[g]; // RULE16
                next_ena[g]  = bus.wdata[3:0] & IMPL_MASK[g];        // RULE17
            end
            // a hardware event beats a software clear in the same cycle
            next_flag[g] = next_flag[g] | (evt_v[g] & IMPL_MASK[g]); // RULE16
        end
        if (bus.wr && bus.addr == OFF_CTRL)
        begin
            next_gie = bus.wdata[GIE_BIT];
        end
        // service entry wins over a software set, so no nesting slips in
        if (svc_ack)
        begin
            next_gie = 1'b0; // RULE19
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request toward the shared vectors and wake-up

    always_comb
    begin
        for (int g = 0; g < NGRP; g++)
        begin
            // a flag with its enable low stays pending but asks for nothing
            next_mf_req[g] = |(next_flag[g] & next_ena[g]) & next_gie; // RULE18 RULE19 RULE21
        end
        // only a rising flag wakes; one set before sleep stays quiet
        next_wake = sleep_or_idle && ((next_flag & ~flag) != '0); // RULE20
    end

    assign irq_req = |mf_req;

    ////////////////////////////////////////////////////////////////////
    // read data, valid in the cycle after the read strobe

    always_comb
    begin
        next_rd_data = RD_ZERO; // RULE11
        if (bus.rd)
        begin
            unique case (bus.addr)
                OFF_GRP0:
                begin
                    next_rd_data[FLAG_LSB+SRC_A_STD] = flag[0][SRC_A_STD]; // RULE1
                    next_rd_data[SRC_A_STD]          = ena[0][SRC_A_STD];  // RULE1
                    next_rd_data[FLAG_LSB+SRC_P_STD] = flag[0][SRC_P_STD]; // RULE2
                    next_rd_data[SRC_P_STD]          = ena[0][SRC_P_STD];  // RULE2
                    next_rd_data[FLAG_LSB+SRC_A_PER] = flag[0][SRC_A_PER]; // RULE3
                    next_rd_data[SRC_A_PER]          = ena[0][SRC_A_PER];  // RULE3
                    next_rd_data[FLAG_LSB+SRC_P_PER] = flag[0][SRC_P_PER]; // RULE4
                    next_rd_data[SRC_P_PER]          = ena[0][SRC_P_PER];  // RULE4
                end
                OFF_GRP1:
                begin
                    next_rd_data[FLAG_LSB+SRC_A_STD] = flag[1][SRC_A_STD]; // RULE5
                    next_rd_data[SRC_A_STD]          = ena[1][SRC_A_STD];  // RULE5
                    next_rd_data[FLAG_LSB+SRC_P_STD] = flag[1][SRC_P_STD]; // RULE6
                    next_rd_data[SRC_P_STD]          = ena[1][SRC_P_STD];  // RULE6
                    next_rd_data[FLAG_LSB+SRC_A_PER] = flag[1][SRC_A_PER]; // RULE7
                    next_rd_data[SRC_A_PER]          = ena[1][SRC_A_PER];  // RULE7
                    next_rd_data[FLAG_LSB+SRC_P_PER] = flag[1][SRC_P_PER]; // RULE8
                    next_rd_data[SRC_P_PER]          = ena[1][SRC_P_PER];  // RULE8
                end
                OFF_GRP2:
                begin
                    // bits 7, 6, 3 and 2 stay at the zero default
                    next_rd_data[FLAG_LSB+SRC_A_PER] = flag[2][SRC_A_PER]; // RULE9
                    next_rd_data[SRC_A_PER]          = ena[2][SRC_A_PER];  // RULE9
                    next_rd_data[FLAG_LSB+SRC_P_PER] = flag[2][SRC_P_PER]; // RULE10
                    next_rd_data[SRC_P_PER]          = ena[2][SRC_P_PER];  // RULE10
                end
                OFF_GRP3:
                begin
                    next_rd_data[FLAG_LSB+SRC_SER]   = flag[3][SRC_SER];   // RULE12
                    next_rd_data[SRC_SER]            = ena[3][SRC_SER];    // RULE12
                    next_rd_data[FLAG_LSB+SRC_SPI]   = flag[3][SRC_SPI];   // RULE13
                    next_rd_data[SRC_SPI]            = ena[3][SRC_SPI];    // RULE13
                    next_rd_data[FLAG_LSB+SRC_EEP]   = flag[3][SRC_EEP];   // RULE14
                    next_rd_data[SRC_EEP]            = ena[3][SRC_EEP];    // RULE14
                    next_rd_data[FLAG_LSB+SRC_LVOLT] = flag[3][SRC_LVOLT]; // RULE15
                    next_rd_data[SRC_LVOLT]          = ena[3][SRC_LVOLT];  // RULE15
                end
                OFF_CTRL:
                begin
                    next_rd_data[GIE_BIT] = global_irq_enable;
                end
                default:
                begin
                    next_rd_data = RD_ZERO;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flag              <= {NGRP{RST_NIB}}; // RULE21
            ena               <= {NGRP{RST_NIB}}; // RULE21
            global_irq_enable <= RST_GIE;
            rd_data           <= RD_ZERO;
            mf_req            <= RST_NIB;
            wake              <= 1'b0;
        end
        else
        begin
            flag              <= next_flag;
            ena               <= next_ena;
            global_irq_enable <= next_gie;
            rd_data           <= next_rd_data;
            mf_req            <= next_mf_req;
            wake              <= next_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!rst_b);

    logic [15:0] flag_flat;
    logic [15:0] evt_flat;
    logic [15:0] impl_flat;

    assign flag_flat = flag;
    assign evt_flat  = evt_v;
    assign impl_flat = IMPL_MASK;

    chk_event_sets_flag: // RULE16
    assert property ((evt_flat & impl_flat) != '0
                     |=> (flag_flat & $past(evt_flat & impl_flat))
                         == $past(evt_flat & impl_flat))
    else $error("event did not set its flag");

    chk_grp0_readback: // RULE1 RULE2 RULE3 RULE4
    assert property (bus.rd && bus.addr == OFF_GRP0
                     |=> rd_data == $past({flag[0], ena[0]}))
    else $error("group 0 read does not match state");

    chk_grp1_write_read: // RULE5 RULE6 RULE7 RULE8 RULE17
    assert property (bus.wr && bus.addr == OFF_GRP1 && evt.grp1 == '0
                     ##1 bus.rd && bus.addr == OFF_GRP1 && evt.grp1 == '0
                     |=> rd_data == $past(bus.wdata, 2))
    else $error("group 1 write then read mismatch");

    chk_grp2_unimpl: // RULE9 RULE10 RULE11
    assert property (bus.rd && bus.addr == OFF_GRP2
                     |=> rd_data[7:6] == 2'h0 && rd_data[3:2] == 2'h0
                         && rd_data[5:4] == $past(flag[2][1:0])
                         && rd_data[1:0] == $past(ena[2][1:0]))
    else $error("group 2 read wrong or unimplemented bits set");

    chk_grp3_readback: // RULE12 RULE13 RULE14 RULE15
    assert property (bus.rd && bus.addr == OFF_GRP3
                     |=> rd_data == $past({flag[3], ena[3]}))
    else $error("group 3 read does not match state");

    chk_req_needs_enable: // RULE18 RULE21
    assert property (flag[0] != '0 && ena[0] == '0 |-> !mf_req[0])
    else $error("group 0 request without an enable");

    chk_req_asserts: // RULE18 RULE21
    assert property ((flag[3] & ena[3]) != '0 && global_irq_enable
                     |-> mf_req[3] && irq_req)
    else $error("enabled pending group 3 flag raised no request");

    chk_ack_clears_gie: // RULE19
    assert property (svc_ack |=> !global_irq_enable && !irq_req [*2])
    else $error("service did not clear the global enable");

    chk_gie_gates_all: // RULE19
    assert property (!global_irq_enable |-> mf_req == '0)
    else $error("request while global enable is low");

    chk_wake_on_rise: // RULE20
    assert property ($past(sleep_or_idle) && (flag_flat & ~$past(flag_flat)) != '0
                     |-> wake)
    else $error("rising flag did not wake the device");

    chk_no_wake_steady: // RULE20
    assert property (flag_flat == $past(flag_flat) |-> !wake)
    else $error("wake without a rising flag");

    // the checks below watch only what this block drives; the bus and
    // the event pulses are taken as given

    // a write lands in the cycle after its strobe unless an event for
    // the same group arrives, which the event check covers instead
    chk_grp0_write_lands: // RULE1 RULE2 RULE3 RULE4 RULE17
    assert property (bus.wr && bus.addr == OFF_GRP0 && evt.grp0 == '0
                     |=> {flag[0], ena[0]} == $past(bus.wdata))
    else $error("group 0 write did not land");

    chk_grp1_write_lands: // RULE5 RULE6 RULE7 RULE8 RULE17
    assert property (bus.wr && bus.addr == OFF_GRP1 && evt.grp1 == '0
                     |=> {flag[1], ena[1]} == $past(bus.wdata))
    else $error("group 1 write did not land");

    chk_grp2_write_lands: // RULE9 RULE10 RULE11
    assert property (bus.wr && bus.addr == OFF_GRP2 && evt.grp2 == '0
                     |=> {flag[2], ena[2]} == ($past(bus.wdata) & 8'h33))
    else $error("group 2 write did not land");

    chk_grp3_write_lands: // RULE12 RULE13 RULE14 RULE15
    assert property (bus.wr && bus.addr == OFF_GRP3 && evt.grp3 == '0
                     |=> {flag[3], ena[3]} == $past(bus.wdata))
    else $error("group 3 write did not land");

    chk_gie_write_lands: // RULE19
    assert property (bus.wr && bus.addr == OFF_CTRL && !svc_ack
                     |=> global_irq_enable == $past(bus.wdata[GIE_BIT]))
    else $error("global enable write did not land");

    chk_gie_holds_low: // RULE19
    assert property (!global_irq_enable && !(bus.wr && bus.addr == OFF_CTRL)
                     |=> !global_irq_enable)
    else $error("global enable rose without a write");

    chk_flag_holds: // RULE16
    assert property (!bus.wr && evt_flat == '0 |=> flag_flat == $past(flag_flat))
    else $error("flag changed with no event or write");

    chk_ena_holds: // RULE17
    assert property (!bus.wr |=> ena == $past(ena))
    else $error("enable changed with no write");

    chk_spare_write_ignored: // RULE16 RULE17
    assert property (bus.wr && bus.addr > OFF_CTRL && evt_flat == '0 && !svc_ack
                     |=> flag_flat == $past(flag_flat) && ena == $past(ena)
                         && global_irq_enable == $past(global_irq_enable))
    else $error("write to a spare index changed state");

    chk_grp2_no_store: // RULE11
    assert property (flag[2][3:2] == 2'h0 && ena[2][3:2] == 2'h0)
    else $error("group 2 unimplemented bit stored");

    chk_grp1_readback: // RULE5 RULE6 RULE7 RULE8
    assert property (bus.rd && bus.addr == OFF_GRP1
                     |=> rd_data == $past({flag[1], ena[1]}))
    else $error("group 1 read does not match state");

    chk_ctrl_readback: // RULE19
    assert property (bus.rd && bus.addr == OFF_CTRL
                     |=> rd_data == {7'h0, $past(global_irq_enable)})
    else $error("control read does not match state");

    chk_spare_read_zero:
    assert property (bus.rd && bus.addr > OFF_CTRL |=> rd_data == RD_ZERO)
    else $error("spare index read not zero");

    // read data is a one-cycle answer; a leftover value would look like
    // a second read to a core that samples late
    chk_rd_data_idle:
    assert property (!bus.rd |=> rd_data == RD_ZERO)
    else $error("read data outside a read answer");

    // request level group by group, enable low included
    chk_grp0_req_level: // RULE1 RULE2 RULE3 RULE4 RULE18 RULE21
    assert property (mf_req[0] == (((flag[0] & ena[0]) != '0) && global_irq_enable))
    else $error("group 0 request level wrong");

    chk_grp1_req_level: // RULE5 RULE6 RULE7 RULE8 RULE18 RULE21
    assert property (mf_req[1] == (((flag[1] & ena[1]) != '0) && global_irq_enable))
    else $error("group 1 request level wrong");

    chk_grp2_req_level: // RULE9 RULE10 RULE18 RULE21
    assert property (mf_req[2] == (((flag[2] & ena[2]) != '0) && global_irq_enable))
    else $error("group 2 request level wrong");

    chk_grp3_req_level: // RULE12 RULE13 RULE14 RULE15 RULE18 RULE21
    assert property (mf_req[3] == (((flag[3] & ena[3]) != '0) && global_irq_enable))
    else $error("group 3 request level wrong");

    chk_grp0_clear_drops: // RULE1 RULE2 RULE3 RULE4 RULE18
    assert property (bus.wr && bus.addr == OFF_GRP0 && bus.wdata[7:4] == 4'h0 && evt.grp0 == '0
                     |=> !mf_req[0])
    else $error("group 0 request stayed after clear");

    chk_grp1_clear_drops: // RULE5 RULE6 RULE7 RULE8 RULE18
    assert property (bus.wr && bus.addr == OFF_GRP1 && bus.wdata[7:4] == 4'h0 && evt.grp1 == '0
                     |=> !mf_req[1])
    else $error("group 1 request stayed after clear");

    chk_grp2_clear_drops: // RULE9 RULE10 RULE18
    assert property (bus.wr && bus.addr == OFF_GRP2 && bus.wdata[7:4] == 4'h0 && evt.grp2 == '0
                     |=> !mf_req[2])
    else $error("group 2 request stayed after clear");

    chk_grp3_clear_drops: // RULE12 RULE13 RULE14 RULE15 RULE18
    assert property (bus.wr && bus.addr == OFF_GRP3 && bus.wdata[7:4] == 4'h0 && evt.grp3 == '0
                     |=> !mf_req[3])
    else $error("group 3 request stayed after clear");

    chk_wake_needs_sleep: // RULE20
    assert property (!sleep_or_idle |=> !wake)
    else $error("wake while the core was running");

    chk_reset_clears_all: // RULE21
    assert property (@(posedge clk) disable iff (1'b0)
                     !rst_b ##1 !rst_b |-> flag_flat == '0 && ena == '0 && mf_req == '0
                         && !global_irq_enable && !wake && rd_data == RD_ZERO)
    else $error("state not cleared by reset");

    cov_masked_pending:
    cover property (evt.grp0[SRC_A_STD] && !ena[0][SRC_A_STD]
                    ##1 flag[0][SRC_A_STD] && !mf_req[0]);

    cov_service_then_nest:
    cover property (irq_req ##1 svc_ack ##1 !global_irq_enable
                    ##[1:8] global_irq_enable);

    cov_wake:
    cover property (sleep_or_idle && evt.grp3[SRC_LVOLT] ##1 wake);

    cov_set_beats_clear:
    cover property (bus.wr && bus.addr == OFF_GRP3
                    && !bus.wdata[FLAG_LSB+SRC_SER] && evt.grp3[SRC_SER]
                    ##1 flag[3][SRC_SER]);

    cov_write_then_read:
    cover property (bus.wr && bus.addr == OFF_GRP1 ##1 bus.rd && bus.addr == OFF_GRP1);

endmodule // mfi_irq_flags

// File: verif/mfi_core_model.sv
// partner model: the core's vector logic, acknowledging a pending request.
// assumes irq_req is a registered level and svc_ack is sampled on clk.
////////////////////////////////////////////////////////////////////////

`timescale 1ns/1ps

module mfi_core_model
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       irq_req,
    input  wire logic       ack_en,
    input  wire logic [3:0] dly,
    output logic            svc_ack
);
    logic [3:0] cnt;

    // one acknowledge per request; the count passes dly so a request
    // still standing in the cycle of the ack is not taken twice
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt     <= 4'h0;
            svc_ack <= 1'b0;
        end
        else
        begin
            svc_ack <= 1'b0;
            if (!(irq_req && ack_en))
                cnt <= 4'h0;
            else if (cnt == dly)
            begin
                svc_ack <= 1'b1;
                cnt     <= cnt + 4'h1;
            end
            else if (cnt < dly)
                cnt <= cnt + 4'h1;
        end
    end
endmodule // mfi_core_model

// File: verif/test_multi_function_irq_flags.sv
// self-checking bench for the flag/enable block against a queue-free model.
// assumes the core model acks only while ack_en is high.
////////////////////////////////////////////////////////////////////////

`timescale 1ns/1ps

module test_multi_function_irq_flags;
    import mfi_pkg::*;
    logic       clk, rst_b, svc_ack, sleep_or_idle, irq_req, global_irq_enable, wake, ack_en;
    mfi_bus_s   bus;
    mfi_evt_s   evt;
    logic [7:0] rd_data;
    logic [3:0] mf_req, dly;
    logic [7:0] m_reg [4];
    logic       m_gie;
    int         n_fail, compares, seed, g, s, i;

    mfi_irq_flags i_dut (.clk(clk), .rst_b(rst_b), .bus(bus), .evt(evt), .svc_ack(svc_ack),
        .sleep_or_idle(sleep_or_idle), .rd_data(rd_data), .mf_req(mf_req), .irq_req(irq_req),
        .global_irq_enable(global_irq_enable), .wake(wake));
    mfi_core_model i_core (.clk(clk), .rst_b(rst_b), .irq_req(irq_req), .ack_en(ack_en),
        .dly(dly), .svc_ack(svc_ack));

    always #10 clk = ~clk;
    always @(posedge clk) if (svc_ack === 1'b1) m_gie = 1'b0;

    task automatic print_verdict();
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // group 2 keeps only its two low sources
    function automatic logic [3:0] nm(input int k);
        return (k == 2) ? 4'h3 : 4'hf;
    endfunction

    task automatic chk();
        logic [3:0] e;
        for (int k = 0; k < 4; k++)
            e[k] = |(m_reg[k][7:4] & m_reg[k][3:0]) & m_gie;
        cmp({2'h0, irq_req, global_irq_enable, mf_req}, {2'h0, |e, m_gie, e});
    endtask

    // a below zero: events only, no write strobe
    task automatic wr(input int a, input logic [7:0] d, input logic [15:0] e);
        logic [3:0] old [4];
        logic       rose;
        rose = 1'b0;
        @(posedge clk);
        bus <= '{addr: a[2:0], wdata: d, wr: (a >= 0), rd: 1'b0};
        evt <= e;
        @(posedge clk);
        bus.wr <= 1'b0;
        evt <= '0;
        for (int k = 0; k < 4; k++)
            old[k] = m_reg[k][7:4];
        if (a >= 0 && a < 4)
            m_reg[a] = d & {nm(a), nm(a)};
        if (a == 4)
            m_gie = d[0] && (svc_ack !== 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            m_reg[k][7:4] = m_reg[k][7:4] | (e[4*k+:4] & nm(k));
            rose = rose | ((m_reg[k][7:4] & ~old[k]) != 4'h0);
        end
        #1;
        chk();
        cmp({7'h0, wake}, {7'h0, sleep_or_idle & rose});
    endtask

    task automatic rd(input int a);
        @(posedge clk);
        bus <= '{addr: a[2:0], wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        cmp(rd_data, (a < 4) ? m_reg[a] : (a == 4) ? {7'h0, m_gie} : 8'h00);
    endtask

    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        bus = '0;
        evt = '0;
        sleep_or_idle = 1'b0;
        ack_en = 1'b0;
        dly = 4'h0;
        n_fail = 0;
        compares = 0;
        seed = 29;
        m_gie = 1'b0;
        foreach (m_reg[k]) m_reg[k] = 8'h00;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 4; i++) rd(i);
        wr(4, 8'h01, '0);
        for (g = 0; g < 4; g++)
        begin
            for (s = 0; s < 4; s++)
            begin
                wr(g, 8'h01 << s, '0);
                wr(-1, 8'h00, 16'h1 << (4 * g + s));
                rd(g);
            end
            wr(g, 8'h00, '0);
        end
        // write then read with no idle cycle between the strobes
        @(posedge clk);
        bus <= '{addr: 3'h1, wdata: 8'ha5, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: 3'h1, wdata: 8'ha5, wr: 1'b0, rd: 1'b1};
        m_reg[1] = 8'ha5;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        cmp(rd_data, 8'ha5);
        // event beside a software clear: the set must win
        wr(3, 8'h0f, 16'h9000);
        rd(3);
        for (i = 0; i < 40; i++)
        begin
            wr(int'({$random(seed)} % 8), 8'($random(seed)), 16'($random(seed)));
            rd(int'({$random(seed)} % 8));
        end
        wr(1, 8'h00, '0);
        @(posedge clk);
        sleep_or_idle <= 1'b1;
        wr(-1, 8'h00, 16'h0080);
        wr(-1, 8'h00, 16'h0080);
        @(posedge clk);
        sleep_or_idle <= 1'b0;
        wr(4, 8'h00, '0);
        wr(3, 8'h11, '0);
        for (i = 0; i < 2; i++)
        begin
            dly = 4'(i * 3);
            ack_en = 1'b1;
            wr(4, 8'h01, '0);
            for (s = 0; s < 20 && global_irq_enable !== 1'b0; s++) @(posedge clk);
            if (s == 20)
            begin
                n_fail++;
                $display("[ERR] %0t no service clear seen", $time);
                print_verdict();
            end
            ack_en = 1'b0;
            #1;
            chk();
            rd(3);
        end
        print_verdict();
    end
endmodule // test_multi_function_irq_flags
